// ===== hw/trace_flush_cfg.svh
// constants for the trace buffer flush and trigger control block
`ifndef TRACE_FLUSH_CFG_SVH
`define TRACE_FLUSH_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CAPTURE_CTL  12'h020
`define OFS_MEM_BUS_CTL  12'h110
`define OFS_BASE_LOW     12'h118
`define OFS_BASE_HIGH    12'h11C
`define OFS_RP_ADVANCE   12'h120
`define OFS_FF_STATUS    12'h300
`define OFS_FF_CONTROL   12'h304
`define RESET_WORD       32'h0000_0000

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define AXI_ADDR_WIDTH   52
`define BASE_HIGH_WIDTH  20
`define RP_WIDTH         52
`define RP_PAD_WIDTH     31

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CAPTURE_EN_BIT   0
`define MODE_LSB         4
`define MODE_MSB         5
`define PROT_SECURE_BIT  1
`define PROT_PRIV_BIT    0
`define FORMATTER_FLUSH_STATUS_HALTED_BIT  1
`define FORMATTER_FLUSH_STATUS_FLUSH_BIT   0
`define FORMATTER_FLUSH_CONTROL_MARKER_BIT  15
`define FORMATTER_FLUSH_CONTROL_HALT_EVT    13
`define FORMATTER_FLUSH_CONTROL_HALT_FL     12
`define FORMATTER_FLUSH_CONTROL_MARK_FL     10
`define FORMATTER_FLUSH_CONTROL_MARK_EVT    9
`define FORMATTER_FLUSH_CONTROL_MARK_IN     8
`define FORMATTER_FLUSH_CONTROL_MANUAL      6
`define FORMATTER_FLUSH_CONTROL_FL_EVT      5
`define FORMATTER_FLUSH_CONTROL_FL_IN       4
`define FORMATTER_FLUSH_CONTROL_TRIG_INS    1
`define FORMATTER_FLUSH_CONTROL_FORMAT_EN   0
`define FORMATTER_FLUSH_CONTROL_WMASK       32'h0000_B773
`define READ_POINTER_ADVANCE_MSB         20
`define READ_POINTER_ADVANCE_MAX         21'h10_0000

// ----------------------------------------------------------------
// inserted stream packets
// ----------------------------------------------------------------
`define TRIGGER_ID       7'h7D
`define FLUSH_MARKER_ID  7'h7B
`define INSERT_DATA      8'h00

`endif

// ===== hw/trace_flush_ctrl.sv
// control and status registers with flush and trigger sequencing
//
// Notes on behaviour
// - secure register bit drives prot bit 1
// - privileged register bit drives prot bit 0
// - low base register gives address bits 31:0
// - zero address width makes low base read-zero
// - high base holds bits above 31, else zero
// - pointer advance ignored unless enabled in mode two
// - advance of 1 to 0x100000 in bits 20:0 moves pointer, else ignored
// - halted status mirrors drained, cleared on enable
// - flush status shows flush, frozen while disabled
// - master-port flush counts as activity only
// - flush completion inserts marker id 0x7B
// - stop formatter on trigger event when set
// - flush request raised; stop and post-amble once the flush completes
// - trigger mark when flush ready arrives
// - trigger mark on trigger event
// - trigger mark on trigger input rising edge
// - manual flush starts flush, self-clears on completion
// - flush on trigger event unless halting on it
// - flush input rising edge starts flush unless halted
// - trigger packet is id 0x7D with byte 0x00
// - disabled means capture enable bit clear
`include "trace_flush_cfg.svh"
`default_nettype none
`timescale 1ns/1ps

module trace_flush_ctrl
  import trace_flush_pkg::*;
(
  input  wire logic                     ref_clk_in,
  input  wire logic                     sys_rst_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [11:0]              paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  output logic                          pslverr_out,
  input  wire logic                     afready_in,
  input  wire logic                     master_flush_in,
  input  wire logic                     fifo_link_in,
  input  wire logic                     trigger_event_in,
  input  wire logic                     trigger_input_in,
  input  wire logic                     flush_input_in,
  input  wire logic                     formatter_drained_in,
  input  wire logic                     flush_written_in,
  output logic                          afvalid_out,
  output logic      [2:0]               arprot_out,
  output logic      [2:0]               awprot_out,
  output logic      [`AXI_ADDR_WIDTH-1:0] buffer_base_out,
  output logic      [`RP_WIDTH-1:0]     read_pointer_out,
  output logic                          insert_valid_out,
  output logic      [6:0]               insert_id_out,
  output logic      [7:0]               insert_data_out,
  output logic                          formatter_halted_out,
  output logic                          postamble_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                        capture_enable;
  logic [1:0]                  mode;
  logic [2:0]                  prot;
  logic [31:0]                 buffer_base_low;
  logic [`BASE_HIGH_WIDTH-1:0] buffer_base_high;
  logic [`RP_WIDTH-1:0]        ram_read_pointer;
  logic [31:0]                 formatter_flush_control;
  logic                        stat_halted;
  logic                        stat_flush;
  logic                        halted;
  logic                        pend_trig;
  logic                        pend_mark;
  logic [1:0]                  prev_in;
  flush_state_t                fl_state;

  localparam bit LOW_ON  = (`AXI_ADDR_WIDTH != 0);
  localparam bit HIGH_ON = (`AXI_ADDR_WIDTH > 32);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  wire logic access     = psel_in & penable_in & pready_out;
  wire logic wr         = access & pwrite_in;
  wire logic hit_ctl    = hit(paddr_in, `OFS_CAPTURE_CTL);
  wire logic hit_axi    = hit(paddr_in, `OFS_MEM_BUS_CTL);
  wire logic hit_blo    = hit(paddr_in, `OFS_BASE_LOW);
  wire logic hit_bhi    = hit(paddr_in, `OFS_BASE_HIGH);
  wire logic hit_read_pointer_advance   = hit(paddr_in, `OFS_RP_ADVANCE);
  wire logic hit_formatter_flush_status   = hit(paddr_in, `OFS_FF_STATUS);
  wire logic hit_formatter_flush_control   = hit(paddr_in, `OFS_FF_CONTROL);
  wire logic mapped     = hit_ctl | hit_axi | hit_blo | hit_bhi | hit_read_pointer_advance
                          | hit_formatter_flush_status | hit_formatter_flush_control;

  // ----------------------------------------------------------------
  // control field views
  // ----------------------------------------------------------------
  wire logic trig_ins      = formatter_flush_control[`FORMATTER_FLUSH_CONTROL_TRIG_INS];
  wire logic normal_fmt    = formatter_flush_control[`FORMATTER_FLUSH_CONTROL_FORMAT_EN] | trig_ins;
  wire logic manual_flush  = formatter_flush_control[`FORMATTER_FLUSH_CONTROL_MANUAL];
  wire logic [1:0] rise_in;

  // rising-edge detect of trigger and flush inputs
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_edge
      wire logic cur = (gi == 0) ? trigger_input_in : flush_input_in;
      assign rise_in[gi] = cur & ~prev_in[gi];
      always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
          prev_in[gi] <= 1'b0;
        end else begin
          prev_in[gi] <= cur;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  wire logic [20:0] adv_val  = pwdata_in[`READ_POINTER_ADVANCE_MSB:0];
  wire logic adv_ok   = wr & hit_read_pointer_advance & capture_enable
                        & (mode == MODE_SW_FIFO_MODE_TWO)
                        & (adv_val != 21'h0) & (adv_val <= `READ_POINTER_ADVANCE_MAX);
  wire logic man_set  = wr & hit_formatter_flush_control & capture_enable
                        & pwdata_in[`FORMATTER_FLUSH_CONTROL_MANUAL];
  wire logic evt_flush = capture_enable & trigger_event_in
                        & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_FL_EVT] & ~formatter_flush_control[`FORMATTER_FLUSH_CONTROL_HALT_EVT];
  wire logic in_flush  = capture_enable & rise_in[1]
                        & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_FL_IN] & ~halted;
  wire logic start_fl  = (fl_state == FL_IDLE)
                        & (man_set | evt_flush | in_flush);
  wire logic got_ready = (fl_state == FL_WAIT) & afready_in;
  wire logic fl_done   = (got_ready & ~normal_fmt)
                        | ((fl_state == FL_DRAIN) & flush_written_in);
  wire logic trig_now  = trig_ins & capture_enable & (
                           (trigger_event_in & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_MARK_EVT])
                         | (rise_in[0] & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_MARK_IN])
                         | (got_ready & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_MARK_FL]));
  wire logic mark_now  = fl_done & normal_fmt & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_MARKER_BIT];
  wire logic halt_now  = capture_enable & (
                           (trigger_event_in & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_HALT_EVT])
                         | (fl_done & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_HALT_FL]));
  wire logic flush_act = (fl_state != FL_IDLE)
                        | (fifo_link_in & master_flush_in);
  wire logic enabling  = wr & hit_ctl & pwdata_in[`CAPTURE_EN_BIT]
                        & ~capture_enable;

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  wire logic [31:0] rd_ctl  = {26'h0, mode, 3'h0, capture_enable};
  wire logic [31:0] rd_axi  = {29'h0, prot};
  wire logic [31:0] rd_blo  = LOW_ON ? buffer_base_low : `RESET_WORD;
  wire logic [31:0] rd_bhi  = HIGH_ON ? {12'h0, buffer_base_high} : `RESET_WORD;
  wire logic [31:0] rd_formatter_flush_status = {30'h0, stat_halted, stat_flush};
  wire logic [31:0] rd_mux  = hit_ctl  ? rd_ctl  :
                              hit_axi  ? rd_axi  :
                              hit_blo  ? rd_blo  :
                              hit_bhi  ? rd_bhi  :
                              hit_formatter_flush_status ? rd_formatter_flush_status :
                              hit_formatter_flush_control ? formatter_flush_control    : `RESET_WORD;  // advance reads zero

  wire logic [31:0] next_formatter_flush_control_w = (pwdata_in & `FORMATTER_FLUSH_CONTROL_WMASK & ~(32'h1 << `FORMATTER_FLUSH_CONTROL_MANUAL))
                                  | (formatter_flush_control & (32'h1 << `FORMATTER_FLUSH_CONTROL_MANUAL));

  // ----------------------------------------------------------------
  // apb slave: one wait state, answer registered
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= `RESET_WORD;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= psel_in & penable_in & ~pready_out;
      prdata_out  <= (psel_in & ~pwrite_in) ? rd_mux : `RESET_WORD;
      pslverr_out <= psel_in & penable_in & ~pready_out & ~mapped;
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      capture_enable   <= 1'b0;
      mode             <= MODE_CB;
      prot             <= 3'h0;
      buffer_base_low  <= `RESET_WORD;
      buffer_base_high <= '0;
    end else begin
      if (wr & hit_ctl) begin
        capture_enable <= pwdata_in[`CAPTURE_EN_BIT];
        mode           <= pwdata_in[`MODE_MSB:`MODE_LSB];
      end
      if (wr & hit_axi) begin
        prot <= {1'b0, pwdata_in[`PROT_SECURE_BIT], pwdata_in[`PROT_PRIV_BIT]};
      end
      if (wr & hit_blo & LOW_ON) begin
        buffer_base_low <= pwdata_in;
      end
      if (wr & hit_bhi & HIGH_ON) begin
        buffer_base_high <= pwdata_in[`BASE_HIGH_WIDTH-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // flush and formatter control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      formatter_flush_control <= `RESET_WORD;
    end else begin
      if (wr & hit_formatter_flush_control) begin
        formatter_flush_control <= next_formatter_flush_control_w;
      end
      // set wins over the self-clear
      if (man_set) begin
        formatter_flush_control[`FORMATTER_FLUSH_CONTROL_MANUAL] <= 1'b1;
      end else if (fl_done) begin
        formatter_flush_control[`FORMATTER_FLUSH_CONTROL_MANUAL] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // read pointer advance
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ram_read_pointer <= '0;
    end else if (adv_ok) begin
      ram_read_pointer <= ram_read_pointer + {{`RP_PAD_WIDTH{1'b0}}, adv_val};
    end
  end

  // ----------------------------------------------------------------
  // flush sequence
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      fl_state    <= FL_IDLE;
      afvalid_out <= 1'b0;
    end else begin
      unique case (fl_state)
        FL_IDLE: begin
          if (start_fl) begin
            fl_state    <= FL_WAIT;
            afvalid_out <= 1'b1;
          end
        end
        FL_WAIT: begin
          if (afready_in) begin
            afvalid_out <= 1'b0;
            fl_state    <= normal_fmt ? FL_DRAIN : FL_IDLE;
          end
        end
        FL_DRAIN: begin
          if (flush_written_in) begin
            fl_state <= FL_IDLE;
          end
        end
        default: begin
          fl_state    <= FL_IDLE;
          afvalid_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // halt, status and post-amble
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      halted        <= 1'b0;
      stat_halted   <= 1'b0;
      stat_flush    <= 1'b0;
      postamble_out <= 1'b0;
    end else begin
      postamble_out <= fl_done & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_HALT_FL] & capture_enable;
      if (halt_now) begin
        halted <= 1'b1;
      end else if (enabling) begin
        halted <= 1'b0;
      end
      if (enabling) begin
        stat_halted <= 1'b0;
        stat_flush  <= 1'b0;
      end else if (capture_enable) begin
        stat_halted <= formatter_drained_in;
        stat_flush  <= flush_act;
      end
    end
  end

  // ----------------------------------------------------------------
  // packet insertion: trigger before flush marker
  // ----------------------------------------------------------------
  wire logic take_trig = pend_trig | trig_now;
  wire logic take_mark = ~take_trig & (pend_mark | mark_now);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pend_trig        <= 1'b0;
      pend_mark        <= 1'b0;
      insert_valid_out <= 1'b0;
      insert_id_out    <= 7'h00;
      insert_data_out  <= 8'h00;
    end else begin
      pend_trig        <= 1'b0;
      pend_mark        <= (pend_mark | mark_now) & take_trig;
      insert_valid_out <= take_trig | take_mark;
      insert_data_out  <= `INSERT_DATA;
      if (take_trig) begin
        insert_id_out <= `TRIGGER_ID;
      end else if (take_mark) begin
        insert_id_out <= `FLUSH_MARKER_ID;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  assign arprot_out           = prot;
  assign awprot_out           = prot;
  assign buffer_base_out      = {buffer_base_high, buffer_base_low};
  assign read_pointer_out     = ram_read_pointer;
  assign formatter_halted_out = halted;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  prot_follow_a: assert property (wr & hit_axi |=>
      arprot_out[1] == $past(pwdata_in[1]) && awprot_out[0] == $past(pwdata_in[0]))
    else $error("prot bits not taken from control write");
  rp_ignore_a: assert property ((wr & hit_read_pointer_advance & ~capture_enable) |=>
      $stable(ram_read_pointer))
    else $error("pointer moved while disabled");
  rp_step_a: assert property (adv_ok |=>
      ram_read_pointer == $past(ram_read_pointer) + {31'h0, $past(adv_val)})
    else $error("pointer advance wrong");
  flush_hold_a: assert property (afvalid_out & ~afready_in |=> afvalid_out)
    else $error("flush request dropped early");
  flush_start_a: assert property (start_fl |=> afvalid_out ##0 fl_state == FL_WAIT)
    else $error("flush not requested");
  manual_clr_a: assert property (fl_done & ~man_set |=> ~formatter_flush_control[`FORMATTER_FLUSH_CONTROL_MANUAL])
    else $error("manual flush not cleared");
  trig_pkt_a: assert property (trig_now |=> insert_valid_out
      && insert_id_out == 7'h7D && insert_data_out == 8'h00)
    else $error("trigger packet wrong");
  stat_freeze_a: assert property (~capture_enable & ~enabling |=>
      $stable(stat_flush) && $stable(stat_halted))
    else $error("status changed while disabled");
  halt_evt_a: assert property (capture_enable & trigger_event_in
      & formatter_flush_control[`FORMATTER_FLUSH_CONTROL_HALT_EVT] |=> formatter_halted_out)
    else $error("formatter not halted on event");

endmodule // trace_flush_ctrl
`default_nettype wire

// ===== hw/trace_flush_pkg.sv
// types for the trace buffer flush and trigger control block
package trace_flush_pkg;

  // operating modes of the trace memory
  typedef enum logic [1:0] {
    MODE_CB   = 2'b00,
    MODE_SW_FIFO_MODE_ONE = 2'b01,
    MODE_RSVD = 2'b10,
    MODE_SW_FIFO_MODE_TWO = 2'b11
  } op_mode_t;

  // slave-side flush sequence
  typedef enum logic [1:0] {
    FL_IDLE  = 2'b00,
    FL_WAIT  = 2'b01,
    FL_DRAIN = 2'b10
  } flush_state_t;

endpackage

// ===== sim/tb.sv
// self-checking bench for the flush and trigger control block
`include "trace_flush_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, err;
  logic        trig_in = 0, flush_in = 0, trig_evt = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd, v, hv;
  logic        drained = 0;
  logic [3:0]  lag = 0;
  logic [51:0] rp = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, afready, written, afvalid, ins_v, halted, post;
  wire  [2:0]  arprot, awprot;
  wire  [51:0] base, rp_out;
  wire  [6:0]  ins_id;
  wire  [7:0]  ins_data;
  int n_errors = 0, checked = 0, cycles = 0, seed = 78915, n_trig = 0, n_mark = 0, n_post = 0;

  always #5 clk = ~clk;

  trace_flush_ctrl u_trace_flush_ctrl (.ref_clk_in(clk), .sys_rst_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .afready_in(afready),
    .master_flush_in(1'b0), .fifo_link_in(1'b0), .trigger_event_in(trig_evt),
    .trigger_input_in(trig_in), .flush_input_in(flush_in), .formatter_drained_in(drained),
    .flush_written_in(written), .afvalid_out(afvalid), .arprot_out(arprot),
    .awprot_out(awprot), .buffer_base_out(base), .read_pointer_out(rp_out),
    .insert_valid_out(ins_v), .insert_id_out(ins_id), .insert_data_out(ins_data),
    .formatter_halted_out(halted), .postamble_out(post));

  trace_source_model u_trace_source_model (.clk_in(clk), .rst_in(rst), .afvalid_in(afvalid),
    .lag_in(lag), .afready_out(afready), .flush_written_out(written));

  task check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // apb transfer; request held until pready is sampled high at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk); psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk); pen <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    pen <= 0;
    @(negedge clk);
  endtask

  task wait_flush(input logic lvl);
    int n;
    n = 0;
    while (afvalid !== lvl && n < 40) begin @(negedge clk); n++; end
  endtask

  // inserted packets counted at settled points
  always @(negedge clk) begin
    if (ins_v === 1'b1) begin
      check(ins_data, `INSERT_DATA);
      if (ins_id === `TRIGGER_ID) n_trig++;
      else if (ins_id === `FLUSH_MARKER_ID) n_mark++;
    end
    if (post === 1'b1) n_post++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin n_errors++; complete_run; end
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    apb(0, `OFS_FF_CONTROL, 0); check(rd, `RESET_WORD);
    apb(0, 12'h0FC, 0); check({err, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1, `OFS_MEM_BUS_CTL, {v[31:2], i[1:0]});
      check({arprot, awprot}, {1'b0, i[1:0], 1'b0, i[1:0]});
    end
    v = $random(seed) & 32'hFFFF_FF00; // aligned base, written while disabled
    apb(1, `OFS_BASE_LOW, v); apb(0, `OFS_BASE_LOW, 0); check(rd, v);
    hv = $random(seed);
    apb(1, `OFS_BASE_HIGH, hv); apb(0, `OFS_BASE_HIGH, 0); check(rd, {12'h0, hv[19:0]});
    check(base, {hv[19:0], v});
    $display("test registers done");
    apb(1, `OFS_RP_ADVANCE, 5); check(rp_out, 0);
    apb(1, `OFS_CAPTURE_CTL, 32'h11); apb(1, `OFS_RP_ADVANCE, 5); check(rp_out, 0);
    apb(1, `OFS_CAPTURE_CTL, 0); apb(1, `OFS_CAPTURE_CTL, 32'h31);
    for (int i = 0; i < 5; i++) begin
      case (i)
        0: v = 0;
        1: v = 1;
        2: v = 32'h10_0000;
        3: v = 32'h10_0001;
        default: v = ($random(seed) & 32'hF_FFFF) | 1;
      endcase
      apb(1, `OFS_RP_ADVANCE, v);
      if (v != 0 && v <= 32'h10_0000) rp += v;
      check(rp_out, rp);
    end
    apb(0, `OFS_RP_ADVANCE, 0); check(rd, 0);
    $display("test pointer done");
    lag <= 9;
    apb(1, `OFS_FF_CONTROL, 32'h9442);
    wait_flush(1); check(afvalid, 1);
    apb(0, `OFS_FF_STATUS, 0); check({rd[0], afvalid}, 2'b11);
    wait_flush(0); repeat (8) @(negedge clk);
    check({halted, n_post[3:0], n_trig[3:0], n_mark[3:0]}, {1'b1, 12'h111});
    apb(0, `OFS_FF_CONTROL, 0); check(rd[6], 0);
    apb(0, `OFS_FF_STATUS, 0); check(rd[0], 0);
    apb(1, `OFS_FF_CONTROL, 32'h10);
    @(posedge clk); flush_in <= 1;
    repeat (8) @(negedge clk); check(afvalid, 0);
    @(posedge clk); flush_in <= 0;
    apb(1, `OFS_CAPTURE_CTL, 0); apb(1, `OFS_CAPTURE_CTL, 32'h01); check(halted, 0);
    lag <= 0;
    @(posedge clk); flush_in <= 1;
    wait_flush(1); check(afvalid, 1);
    wait_flush(0); check(afvalid, 0);
    $display("test flush done");
    apb(1, `OFS_FF_CONTROL, 32'h322);
    @(posedge clk); trig_in <= 1;
    repeat (3) @(negedge clk); check(n_trig, 2);
    @(posedge clk); trig_evt <= 1;
    @(posedge clk); trig_evt <= 0;
    wait_flush(1); check(afvalid, 1);
    @(negedge clk); check(n_trig, 3);
    wait_flush(0);
    apb(1, `OFS_FF_CONTROL, 32'h2022);
    @(posedge clk); trig_evt <= 1;
    @(posedge clk); trig_evt <= 0;
    repeat (5) @(negedge clk); check({afvalid, halted}, 2'b01);
    @(posedge clk); drained <= 1;
    apb(0, `OFS_FF_STATUS, 0); check(rd[1], 1);
    $display("test triggers done");
    complete_run;
  end
endmodule // tb
`default_nettype wire

// ===== sim/trace_source_model.sv
// behavioural trace source and memory path that answer flush requests
`timescale 1ns/1ps
`default_nettype none
module trace_source_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       afvalid_in,
  input  wire logic [3:0] lag_in,
  output logic            afready_out,
  output logic            flush_written_out
);
  logic [3:0] wait_cnt;
  logic [2:0] drain_cnt;

  // acknowledge only after older trace has left, then release at once
  always_ff @(posedge clk_in) begin
    if (rst_in || !afvalid_in || afready_out) begin
      wait_cnt    <= 4'h0;
      afready_out <= 1'b0;
    end else begin
      wait_cnt    <= wait_cnt + 4'h1;
      afready_out <= (wait_cnt >= lag_in);
    end
  end

  // memory path reports flush data written a few cycles later
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drain_cnt         <= 3'h0;
      flush_written_out <= 1'b0;
    end else if (afready_out) begin
      drain_cnt         <= 3'h3;
      flush_written_out <= 1'b0;
    end else begin
      drain_cnt         <= (drain_cnt != 3'h0) ? drain_cnt - 3'h1 : 3'h0;
      flush_written_out <= (drain_cnt == 3'h1);
    end
  end
endmodule // trace_source_model
`default_nettype wire
